// ===== bench/swec_mem.sv
`timescale 1ns/1ns
`default_nettype none
module swec_mem (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [63:0] mem_wdata,
  input  wire logic [7:0]  mem_wcheck,
  input  wire logic [7:0]  mem_wmask,
  output logic             mem_ready,
  output logic             mem_rvalid,
  output logic [63:0]      mem_rdata
);
  logic [63:0] data_q [32];
  logic [7:0]  chk_q [32];
  logic [1:0]  tick_r, rd_pipe_r;
  logic [4:0]  rd_idx_r;
  wire logic   acc = mem_req && mem_ready;
  // Slow mode accepts one request in four cycles
  assign mem_ready = !slow || tick_r == 2'h3;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tick_r <= 2'h0;
      rd_pipe_r <= 2'h0;
      mem_rvalid <= 1'b0;
      mem_rdata <= 64'h0;
      for (int i = 0; i < 32; i++) begin
        data_q[i] <= 64'h0;
        chk_q[i] <= 8'h0;
      end
    end else begin
      tick_r <= tick_r + 2'h1;
      rd_pipe_r <= {rd_pipe_r[0], acc && !mem_we};
      if (acc && !mem_we) rd_idx_r <= mem_addr[7:3];
      mem_rvalid <= rd_pipe_r[1];
      // Stale read data is inverted so it is never mistaken for valid
      mem_rdata <= rd_pipe_r[1] ? data_q[rd_idx_r] : ~mem_rdata;
      if (acc && mem_we)
        for (int i = 0; i < 8; i++)
          if (mem_wmask[i]) begin
            data_q[mem_addr[7:3]][8*i +: 8] <= mem_wdata[8*i +: 8];
            chk_q[mem_addr[7:3]][i] <= mem_wcheck[i];
          end
    end
  end
endmodule // swec_mem
`default_nettype wire

// ===== bench/swec_top_properties.sv
`timescale 1ns/1ns
`default_nettype none
module swec_chk #(parameter AW = 32) (
  input wire logic          clk_sys,
  input wire logic          rst,
  input wire logic          wr_valid,
  input wire logic          wr_ready,
  input wire logic [7:0]    wr_byte_en,
  input wire logic          wr_resp_valid,
  input wire logic          wr_resp_err,
  input wire logic          mem_req,
  input wire logic          mem_we,
  input wire logic [AW-1:0] mem_addr,
  input wire logic [7:0]    mem_wmask,
  input wire logic          mem_ready,
  input wire logic          reg_wr,
  input wire logic          irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic take = wr_valid && wr_ready;
  ////////////////////////////////////////////////////////////////////////////////
  err_in_resp_a: assert property (wr_resp_err |-> wr_resp_valid)
    else $error("error flag outside response");
  resp_pulse_a: assert property (wr_resp_valid |=> !wr_resp_valid)
    else $error("response longer than one cycle");
  resp_bound_a: assert property (take |-> ##[2:40] wr_resp_valid)
    else $error("write not answered");
  empty_skip_a: assert property (take && wr_byte_en == 8'h00
    |=> !mem_req ##1 (wr_resp_valid && !mem_req)) else $error("empty write reached memory");
  write_issued_a: assert property (take && wr_byte_en != 8'h00 |=> mem_req)
    else $error("write not sent to memory");
  req_hold_a: assert property (mem_req && !mem_ready
    |=> mem_req && $stable(mem_addr) && $stable(mem_we)) else $error("memory request dropped");
  rmw_merge_a: assert property (mem_req && !mem_we && mem_ready
    |-> ##[1:20] (mem_req && mem_we && mem_wmask == 8'hFF)) else $error("no merged write");
  irq_sticky_a: assert property ($fell(irq) |-> $past(reg_wr))
    else $error("interrupt dropped without software");
  irq_cause_a: assert property ($rose(irq) && !$past(reg_wr)
    |-> ##[0:40] (wr_resp_valid && wr_resp_err)) else $error("interrupt without error");
  cover property (take && wr_byte_en == 8'h00);
  cover property ($rose(irq));
  cover property (wr_resp_valid && wr_resp_err);
endmodule // swec_chk
bind swec_top swec_chk #(.AW(AW)) u_swec_chk (.clk_sys(clk_sys), .rst(rst),
  .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_byte_en(wr_byte_en),
  .wr_resp_valid(wr_resp_valid), .wr_resp_err(wr_resp_err), .mem_req(mem_req),
  .mem_we(mem_we), .mem_addr(mem_addr), .mem_wmask(mem_wmask), .mem_ready(mem_ready),
  .reg_wr(reg_wr), .irq(irq));
`default_nettype wire

// ===== bench/test_swec_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "swec_map.vh"
module test_swec_top;
  logic        clk_sys, rst, wr_valid, reg_wr, reg_rd, slow, rd_seen, read_modify_write, on;
  logic [31:0] wr_addr, reg_wdata, lim;
  logic [7:0]  wr_byte_cnt, wr_byte_en;
  logic [63:0] wr_data, d, d0;
  logic [3:0]  wr_mst;
  logic [5:0]  reg_addr;
  logic [1:0]  c;
  logic [2:0]  mst_code = 3'h0;
  logic [4:0]  exp_r;
  logic [4:0]  resp_q [$];
  logic [31:0] rd_q [$];
  logic [31:0] va [4] = '{32'h9, 32'h10, 32'h18, 32'h3F};
  logic [7:0]  vn [4] = '{8'h8, 8'h3, 8'h0, 8'h1};
  logic [7:0]  vb [4] = '{8'hFF, 8'h07, 8'hFF, 8'h00};
  int          n_fail, checks;
  wire logic   wr_ready, wr_resp_valid, wr_resp_err, mem_req, mem_we, mem_ready;
  wire logic   mem_rvalid, irq;
  wire logic [3:0]  wr_resp_mst;
  wire logic [31:0] mem_addr, reg_rdata;
  wire logic [63:0] mem_wdata, mem_rdata;
  wire logic [7:0]  mem_wcheck, mem_wmask;
  swec_top u_swec_top (.clk_sys(clk_sys), .rst(rst), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_byte_cnt(wr_byte_cnt),
    .wr_byte_en(wr_byte_en), .wr_data(wr_data), .wr_mst(wr_mst),
    .wr_resp_valid(wr_resp_valid), .wr_resp_err(wr_resp_err), .wr_resp_mst(wr_resp_mst),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_wcheck(mem_wcheck), .mem_wmask(mem_wmask), .mem_ready(mem_ready),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq));
  swec_mem u_swec_mem (.clk_sys(clk_sys), .rst(rst), .slow(slow), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wcheck(mem_wcheck),
    .mem_wmask(mem_wmask), .mem_ready(mem_ready), .mem_rvalid(mem_rvalid),
    .mem_rdata(mem_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  function automatic logic [7:0] par(input logic [63:0] v);
    for (int j = 0; j < 8; j++) par[j] = ^v[8*j +: 8];
  endfunction
  task automatic results;
    $display("comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic reg_w(input logic [5:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_r(input logic [5:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    rd_q.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
  // One write, waits for its response
  task automatic wr(input logic [31:0] a, input logic [7:0] n, input logic [7:0] be,
                    input logic [63:0] v);
    logic       e;
    logic [3:0] m;
    int         k;
    e = on && a <= lim && !read_modify_write && (a[2:0] != 3'h0 || n[2:0] != 3'h0 || n == 8'h0);
    m = 4'($urandom);
    k = 0;
    @(posedge clk_sys);
    wr_valid <= 1'b1;
    wr_addr <= a;
    wr_byte_cnt <= n;
    wr_byte_en <= be;
    wr_data <= v;
    wr_mst <= m;
    resp_q.push_back({e, m});
    do begin @(posedge clk_sys); k++; end while (!wr_ready && k < 50);
    wr_valid <= 1'b0;
    while (resp_q.size() != 0 && k < 100) begin @(posedge clk_sys); k++; end
    chk("pending responses", 0, resp_q.size());
  endtask
  always @(posedge clk_sys) begin
    if (!rst && wr_resp_valid) begin
      exp_r = resp_q.size() ? resp_q.pop_front() : 5'h1F;
      chk("response error and master", exp_r, {wr_resp_err, wr_resp_mst});
    end
    if (rd_seen) chk("register read", rd_q.pop_front(), reg_rdata);
    // Master side keeps only its first data error
    if (!rst && wr_resp_valid && wr_resp_err && mst_code == 3'h0)
      mst_code <= 3'h4;
    rd_seen <= reg_rd;
  end
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    #2000000;
    chk("watchdog", 0, 1);
    results();
  end
  initial begin
    {rst, read_modify_write, on, lim} = {3'b101, 32'hFFFFFFFF};
    {wr_valid, reg_wr, reg_rd, slow, rd_seen} = 5'h0;
    {wr_addr, wr_byte_cnt, wr_byte_en, wr_data, wr_mst, reg_addr, reg_wdata} = '0;
    n_fail = 0;
    checks = 0;
    void'($urandom(42));
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    reg_r(`SWEC_OFS_CTRL, 32'h2);
    reg_r(`SWEC_OFS_EN_SET, 32'h0);
    reg_r(6'h3C, 32'h0);
    $display("reset values done");
    slow <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      d = {$urandom, $urandom};
      if (i == 0) d0 = d;
      wr(32'(i * 8), 8'h8, 8'hFF, d);
      chk("stored word", d, u_swec_mem.data_q[i]);
      chk("stored check", par(d), u_swec_mem.chk_q[i]);
    end
    reg_r(`SWEC_OFS_RAW, 32'h0);
    $display("aligned writes done");
    for (int i = 0; i < 4; i++) wr(va[i], vn[i], vb[i], {$urandom, $urandom});
    chk("untouched word", 64'h0, u_swec_mem.data_q[7]);
    chk("untouched check", 8'h0, u_swec_mem.chk_q[7]);
    reg_r(`SWEC_OFS_RAW, 32'h1);
    reg_r(`SWEC_OFS_ERR_CNT, 32'h4);
    reg_r(`SWEC_OFS_ERR_ADDR, 32'h9);
    chk("master error code", 3'h4, mst_code);
    chk("interrupt", 0, irq);
    $display("violations done");
    reg_w(`SWEC_OFS_EN_SET, 32'h1);
    #1 chk("interrupt", 1, irq);
    wr(32'h21, 8'h8, 8'hFF, {$urandom, $urandom});
    chk("interrupt", 1, irq);
    reg_w(`SWEC_OFS_RAW, 32'h1);
    #1 chk("interrupt", 0, irq);
    reg_w(`SWEC_OFS_EN_CLR, 32'h1);
    wr(32'h2A, 8'h2, 8'h03, {$urandom, $urandom});
    chk("interrupt", 0, irq);
    reg_r(`SWEC_OFS_MSK_STAT, 32'h0);
    reg_w(`SWEC_OFS_RAW, 32'h1);
    $display("interrupt done");
    reg_w(`SWEC_OFS_CTRL, 32'h3);
    read_modify_write = 1'b1;
    d = {$urandom, $urandom};
    wr(32'h0, 8'h1, 8'h01, d);
    chk("merged word", {d0[63:8], d[7:0]}, u_swec_mem.data_q[0]);
    chk("merged check", par({d0[63:8], d[7:0]}), u_swec_mem.chk_q[0]);
    reg_r(`SWEC_OFS_RAW, 32'h0);
    $display("read-modify-write done");
    reg_w(`SWEC_OFS_LIMIT, 32'hFF);
    lim = 32'hFF;
    for (int i = 0; i < 24; i++) begin
      c = 2'($urandom);
      reg_w(`SWEC_OFS_CTRL, {30'h0, c});
      {on, read_modify_write} = c;
      wr(32'($urandom_range(0, 511)), 8'($urandom_range(0, 16)), 8'($urandom),
         {$urandom, $urandom});
    end
    $display("random writes done");
    results();
  end
endmodule // test_swec_top
`default_nettype wire

// ===== common/swec_map.vh
// Function
// R1 - READ_MODIFY_WRITE off: flag writes in protected range unaligned or not whole 64-bit words
// R2 - READ_MODIFY_WRITE on: such writes complete by read-modify-write, no error raised
// R3 - Error drives interrupt only once its enable bit is set via enable-set
// R4 - A violation sets the write-check error bit in raw interrupt status
// R5 - Write with all byte enables low changes neither data nor check bits
// R6 - Sub-quanta write returns an error on the master's status line
// R7 - Master records code 0x4 data error and raises its port error interrupt
// R8 - Cache block writeback ends with one-byte write, byte enables cleared
// R9 - Global writebacks emit no trailing one-byte write
// R10 - Master captures only first port error until software clears it
// R11 - Error stays set until cleared; pending error blocks retrigger
// R12 - One shared error interrupt output for every master
// R13 - Error status rides on the normal write response of that write
`ifndef SWEC_MAP_VH
`define SWEC_MAP_VH

// Register byte offsets
`define SWEC_OFS_CTRL      6'h00
`define SWEC_OFS_RAW       6'h04
`define SWEC_OFS_MSK_STAT  6'h08
`define SWEC_OFS_EN_SET    6'h0C
`define SWEC_OFS_EN_CLR    6'h10
`define SWEC_OFS_BASE      6'h14
`define SWEC_OFS_LIMIT     6'h18
`define SWEC_OFS_ERR_ADDR  6'h1C
`define SWEC_OFS_ERR_MST   6'h20
`define SWEC_OFS_ERR_CNT   6'h24

// ecc_control fields
`define SWEC_CTRL_RMW      0
`define SWEC_CTRL_ECC_ON   1
`define SWEC_CTRL_RST      2'h2

// Interrupt status fields
`define SWEC_IRQ_WR_ERR    0

// Range reset values
`define SWEC_BASE_RST      32'h00000000
`define SWEC_LIMIT_RST     32'hFFFFFFFF

// One 64-bit word
`define SWEC_WORD_BYTES    3
`define SWEC_LANES         8
`define SWEC_BE_NONE       8'h00
`define SWEC_BE_ALL        8'hFF

`endif

// ===== verilog/swec_qual.v
`timescale 1ns/1ns
`default_nettype none
`include "swec_map.vh"

module swec_qual #(
  parameter AW = 32,
  parameter CW = 8
) (
  input  wire [AW-1:0] addr,
  input  wire [CW-1:0] byte_cnt,
  input  wire [7:0]    byte_en,
  input  wire [AW-1:0] base,
  input  wire [AW-1:0] limit,
  input  wire          ecc_on,
  input  wire          read_modify_write_enable,
  output wire          in_range,
  output wire          misfit,
  output wire          flag_err,
  output wire          need_rmw,
  output wire          no_write
);

  wire unaligned;
  wire sub_quanta;

  assign in_range   = ecc_on && (addr >= base) && (addr <= limit);
  assign unaligned  = |addr[`SWEC_WORD_BYTES-1:0];
  assign sub_quanta = (|byte_cnt[`SWEC_WORD_BYTES-1:0]) || (byte_cnt == {CW{1'b0}});
  assign misfit     = in_range && (unaligned || sub_quanta); // R1
  assign flag_err   = misfit && !read_modify_write_enable; // R1 R2
  assign need_rmw   = misfit && read_modify_write_enable && !no_write; // R2
  assign no_write   = (byte_en == `SWEC_BE_NONE); // R5

endmodule // swec_qual

`default_nettype wire

// ===== verilog/swec_top.v
`timescale 1ns/1ns
`default_nettype none
`include "swec_map.vh"

module swec_top #(
  parameter AW = 32,
  parameter CW = 8,
  parameter MW = 4
) (
  input  wire          clk_sys,
  input  wire          rst,
  // Write request from bus masters
  input  wire          wr_valid,
  output wire          wr_ready,
  input  wire [AW-1:0] wr_addr,
  input  wire [CW-1:0] wr_byte_cnt,
  input  wire [7:0]    wr_byte_en,
  input  wire [63:0]   wr_data,
  input  wire [MW-1:0] wr_mst,
  // Write response with error status
  output reg           wr_resp_valid,
  output reg           wr_resp_err,
  output reg  [MW-1:0] wr_resp_mst,
  // SDRAM side
  output reg           mem_req,
  output reg           mem_we,
  output reg  [AW-1:0] mem_addr,
  output reg  [63:0]   mem_wdata,
  output reg  [7:0]    mem_wcheck,
  output reg  [7:0]    mem_wmask,
  input  wire          mem_ready,
  input  wire          mem_rvalid,
  input  wire [63:0]   mem_rdata,
  // Register port
  input  wire [5:0]    reg_addr,
  input  wire [31:0]   reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  output reg  [31:0]   reg_rdata,
  // Shared error interrupt
  output wire          irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function [7:0] check_bits;
    input [63:0] d;
    integer i;
    begin
      check_bits = 8'h00;
      for (i = 0; i < `SWEC_LANES; i = i + 1) begin
        check_bits[i] = ^d[i*8 +: 8];
      end
    end
  endfunction

  function [63:0] merge_lanes;
    input [63:0] old_d;
    input [63:0] new_d;
    input [7:0]  be;
    integer i;
    begin
      merge_lanes = old_d;
      for (i = 0; i < `SWEC_LANES; i = i + 1) begin
        if (be[i]) begin
          merge_lanes[i*8 +: 8] = new_d[i*8 +: 8];
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  localparam ST_IDLE = 3'h0;
  localparam ST_RD   = 3'h1;
  localparam ST_RWT  = 3'h2;
  localparam ST_WR   = 3'h3;
  localparam ST_RESP = 3'h4;

  reg  [2:0]    state_r;
  reg  [2:0]    state_nxt;
  reg  [1:0]    ctrl_r;
  reg           raw_err_r;
  reg           en_err_r;
  reg  [AW-1:0] base_r;
  reg  [AW-1:0] limit_r;
  reg  [AW-1:0] err_addr_r;
  reg  [MW-1:0] err_mst_r;
  reg  [15:0]   err_cnt_r;
  reg  [AW-1:0] cur_addr_r;
  reg  [63:0]   cur_data_r;
  reg  [7:0]    cur_be_r;
  reg  [MW-1:0] cur_mst_r;
  reg           cur_err_r;

  wire in_range;
  wire misfit;
  wire flag_err;
  wire need_rmw;
  wire no_write;
  wire take;
  wire err_event;
  wire reg_hit_raw;

  assign wr_ready = (state_r == ST_IDLE);
  assign take     = wr_valid && wr_ready;

  swec_qual #(
    .AW (AW),
    .CW (CW)
  ) u_qual (
    .addr     (wr_addr),
    .byte_cnt (wr_byte_cnt),
    .byte_en  (wr_byte_en),
    .base     (base_r),
    .limit    (limit_r),
    .ecc_on   (ctrl_r[`SWEC_CTRL_ECC_ON]),
    .read_modify_write_enable   (ctrl_r[`SWEC_CTRL_RMW]),
    .in_range (in_range),
    .misfit   (misfit),
    .flag_err (flag_err),
    .need_rmw (need_rmw),
    .no_write (no_write)
  );

  assign err_event = take && flag_err; // R1 R4

  ////////////////////////////////////////////////////////////////////////////
  // Write sequencer

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (take) begin
          if (no_write) begin
            state_nxt = ST_RESP; // R5
          end else if (need_rmw) begin
            state_nxt = ST_RD; // R2
          end else begin
            state_nxt = ST_WR;
          end
        end
      end
      ST_RD: begin
        if (mem_ready) begin
          state_nxt = ST_RWT;
        end
      end
      ST_RWT: begin
        if (mem_rvalid) begin
          state_nxt = ST_WR;
        end
      end
      ST_WR: begin
        if (mem_ready) begin
          state_nxt = ST_RESP;
        end
      end
      ST_RESP: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r    <= ST_IDLE;
      cur_addr_r <= {AW{1'b0}};
      cur_data_r <= 64'h0000000000000000;
      cur_be_r   <= `SWEC_BE_NONE;
      cur_mst_r  <= {MW{1'b0}};
      cur_err_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (take) begin
        cur_addr_r <= wr_addr;
        cur_data_r <= wr_data;
        cur_be_r   <= wr_byte_en;
        cur_mst_r  <= wr_mst;
        cur_err_r  <= flag_err; // R6
      end else if (state_r == ST_RWT && mem_rvalid) begin
        cur_data_r <= merge_lanes(mem_rdata, cur_data_r, cur_be_r); // R2
        cur_be_r   <= `SWEC_BE_ALL;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SDRAM command

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_req    <= 1'b0;
      mem_we     <= 1'b0;
      mem_addr   <= {AW{1'b0}};
      mem_wdata  <= 64'h0000000000000000;
      mem_wcheck <= 8'h00;
      mem_wmask  <= `SWEC_BE_NONE;
    end else begin
      case (state_nxt)
        ST_RD: begin
          mem_req   <= 1'b1;
          mem_we    <= 1'b0;
          mem_addr  <= take ? wr_addr : cur_addr_r;
          mem_wmask <= `SWEC_BE_NONE;
        end
        ST_WR: begin
          mem_req <= 1'b1;
          mem_we  <= 1'b1;
          if (take) begin
            mem_addr   <= wr_addr;
            mem_wdata  <= wr_data;
            mem_wcheck <= check_bits(wr_data);
            mem_wmask  <= wr_byte_en;
          end else if (state_r == ST_RWT) begin
            mem_addr   <= cur_addr_r;
            mem_wdata  <= merge_lanes(mem_rdata, cur_data_r, cur_be_r);
            mem_wcheck <= check_bits(merge_lanes(mem_rdata, cur_data_r, cur_be_r));
            mem_wmask  <= `SWEC_BE_ALL;
          end
        end
        default: begin
          mem_req   <= 1'b0;
          mem_we    <= 1'b0;
          mem_wmask <= `SWEC_BE_NONE; // R5
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write response

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_resp_valid <= 1'b0;
      wr_resp_err   <= 1'b0;
      wr_resp_mst   <= {MW{1'b0}};
    end else begin
      wr_resp_valid <= (state_r == ST_RESP); // R13
      if (state_r == ST_RESP) begin
        wr_resp_err <= cur_err_r; // R6 R13
        wr_resp_mst <= cur_mst_r;
      end else begin
        wr_resp_err <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and status registers

  assign reg_hit_raw = reg_wr && (reg_addr == `SWEC_OFS_RAW);

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_r     <= `SWEC_CTRL_RST;
      raw_err_r  <= 1'b0;
      en_err_r   <= 1'b0;
      base_r     <= `SWEC_BASE_RST;
      limit_r    <= `SWEC_LIMIT_RST;
      err_addr_r <= {AW{1'b0}};
      err_mst_r  <= {MW{1'b0}};
      err_cnt_r  <= 16'h0000;
    end else begin
      // Set wins over a same-cycle clear
      if (err_event) begin
        raw_err_r <= 1'b1; // R4 R11
      end else if (reg_hit_raw && reg_wdata[`SWEC_IRQ_WR_ERR]) begin
        raw_err_r <= 1'b0; // R11
      end
      // First error address kept while pending
      if (err_event && !raw_err_r) begin
        err_addr_r <= wr_addr;
        err_mst_r  <= wr_mst;
      end
      if (err_event && err_cnt_r != 16'hFFFF) begin
        err_cnt_r <= err_cnt_r + 16'h0001;
      end
      if (reg_wr) begin
        case (reg_addr)
          `SWEC_OFS_CTRL: begin
            ctrl_r <= reg_wdata[1:0];
          end
          `SWEC_OFS_EN_SET: begin
            if (reg_wdata[`SWEC_IRQ_WR_ERR]) begin
              en_err_r <= 1'b1; // R3
            end
          end
          `SWEC_OFS_EN_CLR: begin
            if (reg_wdata[`SWEC_IRQ_WR_ERR]) begin
              en_err_r <= 1'b0;
            end
          end
          `SWEC_OFS_BASE: begin
            base_r <= reg_wdata[AW-1:0];
          end
          `SWEC_OFS_LIMIT: begin
            limit_r <= reg_wdata[AW-1:0];
          end
          `SWEC_OFS_ERR_CNT: begin
            err_cnt_r <= 16'h0000;
          end
          default: begin
            ctrl_r <= ctrl_r;
          end
        endcase
      end
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `SWEC_OFS_CTRL:     reg_rdata <= {30'h00000000, ctrl_r};
        `SWEC_OFS_RAW:      reg_rdata <= {31'h00000000, raw_err_r};
        `SWEC_OFS_MSK_STAT: reg_rdata <= {31'h00000000, raw_err_r & en_err_r};
        `SWEC_OFS_EN_SET:   reg_rdata <= {31'h00000000, en_err_r};
        `SWEC_OFS_EN_CLR:   reg_rdata <= {31'h00000000, en_err_r};
        `SWEC_OFS_BASE:     reg_rdata <= base_r;
        `SWEC_OFS_LIMIT:    reg_rdata <= limit_r;
        `SWEC_OFS_ERR_ADDR: reg_rdata <= err_addr_r;
        `SWEC_OFS_ERR_MST:  reg_rdata <= {{(32-MW){1'b0}}, err_mst_r};
        `SWEC_OFS_ERR_CNT:  reg_rdata <= {16'h0000, err_cnt_r};
        default:            reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // One level output for all masters
  assign irq = raw_err_r & en_err_r; // R3 R11 R12

endmodule // swec_top

`default_nettype wire
